// *** spcd_pkg.sv ***
// Constants, types and checksum function of the SPI checksum and command decoder
package spcd_pkg;
    localparam logic [7:0] CMD_LOCK_CTRL   = 8'hc1;
    localparam logic [7:0] CMD_UNLOCK_CTRL = 8'hc2;
    localparam logic [7:0] CMD_LOCK_BIST   = 8'hf1;
    localparam logic [7:0] CMD_UNLOCK_BIST = 8'hf2;
    localparam logic [7:0] CMD_LOCK_CFG    = 8'hc4;
    localparam logic [7:0] CMD_UNLOCK_CFG  = 8'hc7;
    localparam logic [7:0] CMD_CLR_WAKE    = 8'hde;
    localparam logic [7:0] CMD_RST_REQ     = 8'hf8;
    localparam logic [7:0] CMD_CLR_ASD     = 8'hf4;
    localparam logic [7:0] CMD_SET_ASD     = 8'hf7;
    localparam logic [7:0] CMD_RD_REV      = 8'h01;
    localparam logic [7:0] CMD_RD_ID       = 8'h02;
    localparam logic [7:0] CMD_RD_STAT1    = 8'h07;
    localparam logic [7:0] CMD_RD_STAT2    = 8'h08;
    localparam logic [7:0] CMD_WR_CFG1     = 8'hfb;
    localparam logic [7:0] CMD_WR_CFG2     = 8'hfd;
    localparam logic [7:0] CMD_RD_CFG1     = 8'h0b;
    localparam logic [7:0] KEY_LOCK        = 8'h55;
    localparam logic [7:0] KEY_UNLOCK      = 8'haa;
    localparam logic [7:0] KEY_WAKE        = 8'h8e;
    localparam logic [7:0] KEY_RST         = 8'h5a;
    localparam logic [7:0] CRC_POLY        = 8'h07;
    localparam logic [7:0] CRC_INIT        = 8'hff;
    localparam logic [2:0] STAT_PATTERN    = 3'h5;
    localparam logic [4:0] LEN_CRC         = 5'h18;
    localparam logic [4:0] LEN_PLAIN       = 5'h10;
    localparam logic [4:0] LEN_MAX         = 5'h1f;
    localparam int         CFG1_CRC_BIT    = 0;
    localparam logic [7:0] CFG1_RST        = 8'h00;
    localparam logic [7:0] CFG2_RST        = 8'h00;
    localparam logic       LOCK_RST        = 1'b0;
    localparam logic       ASD_RST         = 1'b0;
    // Identification values are arbitrary
    localparam logic [7:0] REVISION_VAL    = 8'h10;
    localparam logic [7:0] IDENTITY_VAL    = 8'h3c;
    localparam int         CS_HIGH_NS      = 788;
    localparam int         CLK_NS          = 20;
    localparam int         CS_HIGH_CYC     = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_BUSY = 3'h2,
        ST_EVAL = 3'h4
    } spcd_st_e;

    function automatic logic [7:0] spcd_crc8(input logic [15:0] bits);
        logic [7:0] r;
        logic       fb;
        r = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            fb = r[7] ^ bits[i];
            r  = {r[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
        end
        return ~r;
    endfunction

    localparam logic [23:0] TX_RST = {STAT_PATTERN, 5'h00, 8'h00,
                                      spcd_crc8({STAT_PATTERN, 13'h0000})};
endpackage

// *** spcd_top.sv ***
// SPI slave checksum handling and single-command decoder
`timescale 1ns/100ps
module spcd_top
    import spcd_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       spi_sck,
    input  wire logic       chip_select_n,
    input  wire logic       spi_sdi,
    output logic            spi_sdo,
    output logic            spi_sdo_oe_n,
    input  wire logic       diag_state,
    input  wire logic       reset_state,
    input  wire logic [7:0] status_one,
    input  wire logic [7:0] status_two,
    input  wire logic       crc_err_clear,
    output logic            control_lock,
    output logic            selftest_lock,
    output logic            config_lock,
    output logic            autostart_inhibit_bit,
    output logic            clear_wake_event,
    output logic            reset_request,
    output logic [7:0]      config_one,
    output logic [7:0]      config_two,
    output logic            master_crc_err,
    output logic            frame_invalid
);
    logic        rst_s1_q;
    logic        rst_n;
    logic        cs_s1_q;
    logic        cs_s2_q;
    logic        cs_s3_q;
    spcd_st_e    st_q;
    spcd_st_e    st_d;
    logic        inv_q;
    logic        inv_d;
    logic        crc_err_q;
    logic        crc_err_d;
    logic        ctrl_lock_q;
    logic        ctrl_lock_d;
    logic        bist_lock_q;
    logic        bist_lock_d;
    logic        cfg_lock_q;
    logic        cfg_lock_d;
    logic        asd_q;
    logic        asd_d;
    logic        wake_q;
    logic        wake_d;
    logic        rreq_q;
    logic        rreq_d;
    logic [7:0]  cfg1_q;
    logic [7:0]  cfg1_d;
    logic [7:0]  cfg2_q;
    logic [7:0]  cfg2_d;
    logic [23:0] tx_word_q;
    logic [23:0] tx_word_d;
    logic        rx_armed_q;
    logic [4:0]  cnt_q;
    logic [4:0]  cnt_d;
    logic [23:0] rx_q;
    logic [23:0] rx_d;
    logic        tx_armed_q;
    logic        sdo_q;
    logic        sdo_d;
    logic        oe_n_q;
    logic [23:0] tx_sh_q;
    logic [23:0] tx_sh_d;
    logic        crc_on;
    logic        len_ok;
    logic        crc_ok;
    logic        good;
    logic        known;
    logic [7:0]  cmd;
    logic [7:0]  dat;
    logic [7:0]  rdata;
    logic [7:0]  stat;

    // Reset release through two flops
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // Chip select synchroniser and edge history
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
        end else begin
            cs_s1_q <= chip_select_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
        end
    end

    // Receive side on the link clock: sample on falling edge
    always_comb begin
        if (rx_armed_q) begin
            cnt_d = 5'h01;
            rx_d  = {23'h000000, spi_sdi};
        end else begin
            cnt_d = (cnt_q == LEN_MAX) ? LEN_MAX : cnt_q + 5'h01;
            rx_d  = {rx_q[22:0], spi_sdi};
        end
    end

    always_ff @(negedge spi_sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            rx_armed_q <= 1'b1;
        end else begin
            rx_armed_q <= 1'b0;
        end
    end

    // Held after select rises; read only once the link is idle
    always_ff @(negedge spi_sck) begin
        cnt_q <= cnt_d;
        rx_q  <= rx_d;
    end

    // Transmit side on the link clock: launch on rising edge
    always_comb begin
        if (tx_armed_q) begin
            sdo_d   = tx_word_q[23];
            tx_sh_d = {tx_word_q[22:0], 1'b0};
        end else begin
            sdo_d   = tx_sh_q[23];
            tx_sh_d = {tx_sh_q[22:0], 1'b0};
        end
    end

    always_ff @(posedge spi_sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            tx_armed_q <= 1'b1;
            sdo_q      <= 1'b0;
            oe_n_q     <= 1'b1;
        end else begin
            tx_armed_q <= 1'b0;
            sdo_q      <= sdo_d;
            oe_n_q     <= 1'b0;
        end
    end

    always_ff @(posedge spi_sck) begin
        tx_sh_q <= tx_sh_d;
    end

    // Frame decode, evaluated once select has risen
    always_comb begin
        crc_on = cfg1_q[CFG1_CRC_BIT];
        len_ok = (cnt_q == (crc_on ? LEN_CRC : LEN_PLAIN));
        cmd    = crc_on ? rx_q[23:16] : rx_q[15:8];
        dat    = crc_on ? rx_q[15:8] : rx_q[7:0];
        crc_ok = !crc_on || (spcd_crc8({cmd, dat}) == rx_q[7:0]);
        good   = len_ok && crc_ok;
        known  = 1'b1;
        rdata  = 8'h00;
        unique case (cmd)
            CMD_LOCK_CTRL, CMD_UNLOCK_CTRL, CMD_LOCK_BIST, CMD_UNLOCK_BIST,
            CMD_LOCK_CFG, CMD_UNLOCK_CFG, CMD_CLR_WAKE, CMD_RST_REQ,
            CMD_CLR_ASD, CMD_SET_ASD, CMD_WR_CFG1, CMD_WR_CFG2: begin
                rdata = 8'h00;
            end
            CMD_RD_REV: begin
                rdata = REVISION_VAL;
            end
            CMD_RD_ID: begin
                rdata = IDENTITY_VAL;
            end
            CMD_RD_STAT1: begin
                rdata = status_one;
            end
            CMD_RD_STAT2: begin
                rdata = status_two;
            end
            CMD_RD_CFG1: begin
                rdata = cfg1_q;
            end
            default: begin
                known = 1'b0;
            end
        endcase
        if (!good) begin
            rdata = 8'h00;
        end
    end

    // Control state next values
    always_comb begin
        st_d        = st_q;
        inv_d       = inv_q;
        crc_err_d   = crc_err_q && !crc_err_clear;
        ctrl_lock_d = ctrl_lock_q;
        bist_lock_d = bist_lock_q;
        cfg_lock_d  = cfg_lock_q;
        asd_d       = asd_q;
        wake_d      = 1'b0;
        rreq_d      = 1'b0;
        cfg1_d      = cfg1_q;
        cfg2_d      = cfg2_q;
        tx_word_d   = tx_word_q;
        stat        = {STAT_PATTERN, 5'h00};
        unique case (st_q)
            ST_IDLE: begin
                if (!cs_s3_q) begin
                    st_d = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (cs_s3_q) begin
                    st_d = ST_EVAL;
                end
            end
            ST_EVAL: begin
                st_d  = ST_IDLE;
                inv_d = !(good && known);
                if (len_ok && !crc_ok) begin
                    crc_err_d = 1'b1;
                end
                if (good) begin
                    if (cmd == CMD_LOCK_CTRL && dat == KEY_LOCK) begin
                        ctrl_lock_d = 1'b1;
                    end
                    if (cmd == CMD_UNLOCK_CTRL && dat == KEY_UNLOCK) begin
                        ctrl_lock_d = 1'b0;
                    end
                    if (cmd == CMD_LOCK_BIST && dat == KEY_LOCK) begin
                        bist_lock_d = 1'b1;
                    end
                    if (cmd == CMD_UNLOCK_BIST && dat == KEY_UNLOCK) begin
                        bist_lock_d = 1'b0;
                    end
                    if (cmd == CMD_LOCK_CFG && dat == KEY_LOCK) begin
                        cfg_lock_d = 1'b1;
                    end
                    if (cmd == CMD_UNLOCK_CFG && dat == KEY_UNLOCK) begin
                        cfg_lock_d = 1'b0;
                    end
                    if (cmd == CMD_CLR_WAKE && dat == KEY_WAKE) begin
                        wake_d = 1'b1;
                    end
                    if (cmd == CMD_RST_REQ && dat == KEY_RST) begin
                        rreq_d = 1'b1;
                    end
                    if (cmd == CMD_CLR_ASD && dat == KEY_LOCK) begin
                        asd_d = 1'b0;
                    end
                    if (cmd == CMD_SET_ASD && dat == KEY_UNLOCK) begin
                        asd_d = 1'b1;
                    end
                    if (diag_state && !cfg_lock_q) begin
                        if (cmd == CMD_WR_CFG1) begin
                            cfg1_d = dat;
                        end
                        if (cmd == CMD_WR_CFG2) begin
                            cfg2_d = dat;
                        end
                    end
                end
                stat      = {STAT_PATTERN, 4'h0, inv_d};
                tx_word_d = {stat, rdata, spcd_crc8({stat, rdata})};
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        if (reset_state) begin
            inv_d       = 1'b0;
            ctrl_lock_d = LOCK_RST;
            bist_lock_d = LOCK_RST;
            cfg_lock_d  = LOCK_RST;
            asd_d       = ASD_RST;
            cfg1_d      = CFG1_RST;
            cfg2_d      = CFG2_RST;
            tx_word_d   = TX_RST;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q        <= ST_IDLE;
            inv_q       <= 1'b0;
            crc_err_q   <= 1'b0;
            ctrl_lock_q <= LOCK_RST;
            bist_lock_q <= LOCK_RST;
            cfg_lock_q  <= LOCK_RST;
            asd_q       <= ASD_RST;
            wake_q      <= 1'b0;
            rreq_q      <= 1'b0;
            cfg1_q      <= CFG1_RST;
            cfg2_q      <= CFG2_RST;
            tx_word_q   <= TX_RST;
        end else begin
            st_q        <= st_d;
            inv_q       <= inv_d;
            crc_err_q   <= crc_err_d;
            ctrl_lock_q <= ctrl_lock_d;
            bist_lock_q <= bist_lock_d;
            cfg_lock_q  <= cfg_lock_d;
            asd_q       <= asd_d;
            wake_q      <= wake_d;
            rreq_q      <= rreq_d;
            cfg1_q      <= cfg1_d;
            cfg2_q      <= cfg2_d;
            tx_word_q   <= tx_word_d;
        end
    end

    assign spi_sdo               = sdo_q;
    assign spi_sdo_oe_n          = oe_n_q;
    assign control_lock          = ctrl_lock_q;
    assign selftest_lock         = bist_lock_q;
    assign config_lock           = cfg_lock_q;
    assign autostart_inhibit_bit = asd_q;
    assign clear_wake_event      = wake_q;
    assign reset_request         = rreq_q;
    assign config_one            = cfg1_q;
    assign config_two            = cfg2_q;
    assign master_crc_err        = crc_err_q;
    assign frame_invalid         = inv_q;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    stat_pattern_a: assert property (tx_word_q[23:21] == STAT_PATTERN)
        else $error("Status byte lost its fixed pattern");

    slave_crc_a: assert property (
        tx_word_q[7:0] == spcd_crc8(tx_word_q[23:8]))
        else $error("Slave checksum does not match status and data");

    eval_after_cs_a: assert property (st_q == ST_EVAL |-> cs_s3_q && $past(cs_s3_q))
        else $error("Frame evaluated while select still low");

    crc_flag_a: assert property (
        st_q == ST_EVAL && len_ok && !crc_ok |=> crc_err_q)
        else $error("Checksum mismatch did not set error flag");

    inv_bit_a: assert property (
        st_q == ST_EVAL && !good && !reset_state |=> tx_word_q[16] && inv_q)
        else $error("Bad frame not reported in next status");

    no_update_a: assert property (
        st_q == ST_EVAL && !good && !reset_state |=>
        $stable(cfg1_q) && $stable(cfg2_q) && $stable(ctrl_lock_q) && !wake_q && !rreq_q)
        else $error("Discarded frame changed state");

    cfg_locked_a: assert property (
        st_q == ST_EVAL && cfg_lock_q && !reset_state |=> $stable(cfg1_q) && $stable(cfg2_q))
        else $error("Write passed the configuration lock");

    lock_key_a: assert property (
        st_q == ST_EVAL && good && cmd == CMD_LOCK_CTRL && dat == KEY_LOCK
        && !reset_state |=> ctrl_lock_q)
        else $error("Control lock key not applied");

    rst_defaults_a: assert property (
        reset_state |=> !inv_q && cfg1_q == CFG1_RST && !cfg_lock_q && tx_word_q == TX_RST)
        else $error("Reset state did not reload defaults");

    wake_pulse_a: assert property (wake_q |=> !wake_q)
        else $error("Wake clear pulse longer than one cycle");
endmodule

// *** spcd_spi_master.sv ***
// SPI master model that frames command words toward the decoder
`timescale 1ns/100ps
module spcd_spi_master (
    output logic      spi_sck,
    output logic      chip_select_n,
    output logic      spi_sdi,
    input  wire logic spi_sdo
);
    initial begin
        spi_sck       = 1'b0;
        chip_select_n = 1'b0;
        spi_sdi       = 1'b0;
        // Clean select rise once every process waits, so the link logic arms
        #1;
        chip_select_n = 1'b1;
    end

    // Shifts the low nbits of tx MSB first, returns the bits read back
    task automatic xfer(input logic [23:0] tx, input int nbits, output logic [23:0] rx);
        rx = 24'h000000;
        #7;
        chip_select_n = 1'b0;
        #40;
        for (int i = nbits - 1; i >= 0; i--) begin
            spi_sck = 1'b1;
            spi_sdi = tx[i];
            #16;
            spi_sck = 1'b0;
            rx = {rx[22:0], spi_sdo};
            #16;
        end
        #20;
        chip_select_n = 1'b1;
        #5;
        spi_sdi = ~spi_sdi;
        #1000;
    endtask
endmodule

// *** tb_top.sv ***
// Self-checking testbench for the SPI checksum and command decoder
`timescale 1ns/100ps
module tb_top;
    import spcd_pkg::*;
    logic        clk_sys, resetn, spi_sck, chip_select_n, spi_sdi, spi_sdo, spi_sdo_oe_n;
    logic        diag_state, reset_state, crc_err_clear, crc_on;
    logic        control_lock, selftest_lock, config_lock, autostart_inhibit_bit;
    logic        clear_wake_event, reset_request, master_crc_err, frame_invalid;
    logic [7:0]  status_one, status_two, config_one, config_two, stat_b, data_b;
    logic [23:0] rsp;
    int          n_fail, comparisons, n_wake, n_rst, cycles;
    logic [7:0]  kc [9] = '{8'hc1, 8'hf1, 8'hc4, 8'hf7, 8'hc2, 8'hf2, 8'hc7, 8'hf4, 8'hc1};
    logic [7:0]  kd [9] = '{8'h55, 8'h55, 8'h55, 8'haa, 8'haa, 8'haa, 8'haa, 8'h55, 8'haa};
    logic [3:0]  ke [9] = '{4'h8, 4'hc, 4'he, 4'hf, 4'h7, 4'h3, 4'h1, 4'h0, 4'h0};

    spcd_top i_dut (.clk_sys(clk_sys), .resetn(resetn), .spi_sck(spi_sck),
        .chip_select_n(chip_select_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
        .spi_sdo_oe_n(spi_sdo_oe_n), .diag_state(diag_state), .reset_state(reset_state),
        .status_one(status_one), .status_two(status_two), .crc_err_clear(crc_err_clear),
        .control_lock(control_lock), .selftest_lock(selftest_lock),
        .config_lock(config_lock), .autostart_inhibit_bit(autostart_inhibit_bit),
        .clear_wake_event(clear_wake_event), .reset_request(reset_request),
        .config_one(config_one), .config_two(config_two),
        .master_crc_err(master_crc_err), .frame_invalid(frame_invalid));

    spcd_spi_master i_mst (.spi_sck(spi_sck), .chip_select_n(chip_select_n),
        .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

    always #10 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        if (clear_wake_event === 1'b1) n_wake++;
        if (reset_request === 1'b1) n_rst++;
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    function automatic logic [7:0] calc_crc(input logic [15:0] v);
        logic [7:0] r;
        r = 8'hff;
        for (int i = 15; i >= 0; i--) begin
            r = {r[6:0], 1'b0} ^ ((r[7] ^ v[i]) ? 8'h07 : 8'h00);
        end
        return ~r;
    endfunction

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One frame in the current mode; bad spoils the master checksum
    task automatic frame(input logic [7:0] cmd, input logic [7:0] dat, input logic bad);
        if (crc_on) begin
            i_mst.xfer({cmd, dat, calc_crc({cmd, dat}) ^ {8{bad}}}, 24, rsp);
            {stat_b, data_b} = rsp[23:8];
            chk(rsp[7:0], calc_crc(rsp[23:8]));
        end else begin
            i_mst.xfer({8'h00, cmd, dat}, 16, rsp);
            {stat_b, data_b} = rsp[15:0];
        end
        chk(stat_b[7:5], STAT_PATTERN);
        chk(spi_sdo_oe_n, 1'b1);
    endtask

    // Raises reset_state or crc_err_clear for a single clock cycle
    task automatic pulse_in(input logic to_rst);
        @(posedge clk_sys);
        #1;
        if (to_rst) begin
            reset_state = 1'b1;
        end else begin
            crc_err_clear = 1'b1;
        end
        @(posedge clk_sys);
        #1;
        reset_state   = 1'b0;
        crc_err_clear = 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic t_reset();
        chk({control_lock, selftest_lock, config_lock, autostart_inhibit_bit}, 4'h0);
        chk({master_crc_err, frame_invalid, config_one, config_two}, 18'h00000);
        $display("test reset done");
    endtask

    task automatic t_reads();
        logic [7:0] rc [5] = '{CMD_RD_REV, CMD_RD_ID, CMD_RD_STAT1, CMD_RD_STAT2, CMD_RD_CFG1};
        logic [7:0] re [5] = '{REVISION_VAL, IDENTITY_VAL, 8'ha5, 8'h3c, 8'h00};
        for (int i = 0; i <= 5; i++) begin
            frame(rc[i % 5], 8'h00, 1'b0);
            if (i > 0) chk(data_b, re[i - 1]);
            chk(stat_b[0], 1'b0);
        end
        $display("test reads done");
    endtask

    task automatic t_keys();
        int w;
        int r;
        for (int i = 0; i < 9; i++) begin
            frame(kc[i], kd[i], 1'b0);
            chk({control_lock, selftest_lock, config_lock, autostart_inhibit_bit}, ke[i]);
        end
        w = n_wake;
        r = n_rst;
        frame(CMD_CLR_WAKE, KEY_WAKE, 1'b0);
        chk(n_wake, w + 1);
        chk(n_rst, r);
        frame(CMD_RST_REQ, KEY_RST, 1'b0);
        chk(n_rst, r + 1);
        chk(n_wake, w + 1);
        $display("test keys done");
    endtask

    task automatic t_cfg();
        frame(CMD_WR_CFG1, 8'h01, 1'b0);
        chk(config_one, 8'h00);
        @(posedge clk_sys);
        #1 diag_state = 1'b1;
        frame(CMD_LOCK_CFG, KEY_LOCK, 1'b0);
        frame(CMD_WR_CFG2, 8'h5a, 1'b0);
        chk(config_two, 8'h00);
        frame(CMD_UNLOCK_CFG, KEY_UNLOCK, 1'b0);
        frame(CMD_WR_CFG2, 8'h5a, 1'b0);
        chk(config_two, 8'h5a);
        frame(CMD_WR_CFG1, 8'h01, 1'b0);
        chk(config_one, 8'h01);
        crc_on = 1'b1;
        @(posedge clk_sys);
        #1 diag_state = 1'b0;
        frame(CMD_RD_CFG1, 8'h00, 1'b0);
        frame(CMD_RD_REV, 8'h00, 1'b0);
        chk(data_b, 8'h01);
        $display("test config done");
    endtask

    task automatic t_crc();
        frame(CMD_LOCK_CTRL, KEY_LOCK, 1'b0);
        chk({control_lock, master_crc_err, frame_invalid}, 3'h4);
        frame(CMD_UNLOCK_CTRL, KEY_UNLOCK, 1'b1);
        chk({control_lock, master_crc_err, frame_invalid}, 3'h7);
        frame(CMD_UNLOCK_CTRL, KEY_UNLOCK, 1'b0);
        chk(stat_b[0], 1'b1);
        chk({control_lock, frame_invalid}, 2'h0);
        pulse_in(1'b0);
        chk(master_crc_err, 1'b0);
        i_mst.xfer({8'h00, CMD_LOCK_CTRL, KEY_LOCK}, 16, rsp);
        chk({control_lock, master_crc_err, frame_invalid}, 3'h1);
        $display("test checksum done");
    endtask

    task automatic t_rstate();
        pulse_in(1'b1);
        chk({config_one, config_two, frame_invalid}, 17'h00000);
        crc_on = 1'b0;
        frame(CMD_RD_REV, 8'h00, 1'b0);
        frame(CMD_RD_ID, 8'h00, 1'b0);
        chk(data_b, REVISION_VAL);
        frame(8'h3e, 8'h00, 1'b0);
        chk(frame_invalid, 1'b1);
        $display("test reset state done");
    endtask

    initial begin
        clk_sys       = 1'b0;
        resetn        = 1'b0;
        diag_state    = 1'b0;
        reset_state   = 1'b0;
        crc_err_clear = 1'b0;
        crc_on        = 1'b0;
        status_one    = 8'ha5;
        status_two    = 8'h3c;
        repeat (5) @(posedge clk_sys);
        #1 resetn = 1'b1;
        repeat (5) @(posedge clk_sys);
        t_reset();
        t_reads();
        t_keys();
        t_cfg();
        t_crc();
        t_rstate();
        end_of_test();
    end
endmodule
